// file: rtl/spd_pkg.sv
// Constants, field positions and state types of the DMA serial port.
// Assumes a 20 MHz unit clock and a 32-bit classic Wishbone master.
package spd_pkg;
   localparam int          CLK_HZ    = 20000000;
   localparam int          BAUD_DEF  = 9600;
   localparam int          DATA_W    = 8;
   localparam int          CNT_W     = 16;
   localparam int          ADR_W     = 5;
   // Register byte offsets.
   localparam logic [4:0]  OFS_CTRL  = 5'h00;
   localparam logic [4:0]  OFS_BAUD  = 5'h04;
   localparam logic [4:0]  OFS_FMT   = 5'h08;
   localparam logic [4:0]  OFS_IRQ   = 5'h0C;
   localparam logic [4:0]  OFS_STAT  = 5'h10;
   // Control register bits.
   localparam int          CTRL_TXE  = 0;
   localparam int          CTRL_RXE  = 1;
   localparam int          CTRL_TXPS = 2;
   localparam int          CTRL_RXPS = 3;
   localparam int          CTRL_W    = 4;
   // Interrupt flag bits, write one to clear.
   localparam int          IRQ_TX1   = 0;
   localparam int          IRQ_TX2   = 1;
   localparam int          IRQ_RX1   = 2;
   localparam int          IRQ_RX2   = 3;
   localparam int          IRQ_BRK   = 4;
   localparam int          IRQ_OVR   = 5;
   localparam int          IRQ_W     = 6;
   // Frame format bits: length code (data bits = code + 5), stop, parity.
   localparam int          FMT_LEN   = 0;
   localparam int          FMT_STOP2 = 2;
   localparam int          FMT_PAR   = 3;
   localparam int          FMT_ODD   = 4;
   localparam int          FMT_W     = 5;
   localparam logic [4:0]  FMT_RST   = 5'h03;
   localparam logic [2:0]  LEN_BASE  = 3'h4;
   // Baud selection holds clock cycles per bit.
   localparam logic [15:0] BAUD_RST  = 16'(CLK_HZ / BAUD_DEF);
   typedef enum logic [2:0] {SPD_IDLE, SPD_START, SPD_DATA, SPD_PAR, SPD_STOP} spd_st_t;
endpackage

// file: rtl/spd_serial_unit.sv
// Serial unit with DMA transmit and receive paths and page-boundary stops.
// Assumes synchronous rxd, a DMA controller with req/ack handshakes that
// marks boundary words, and a classic Wishbone master for the registers.
`timescale 1ns/1ns
`default_nettype none
module spd_serial_unit
(
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        ce,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   output var  logic        tx_dma_req,
   input  wire logic        tx_dma_ack,
   input  wire logic [7:0]  tx_dma_data,
   input  wire logic        tx_dma_page1,
   input  wire logic        tx_dma_page2,
   output var  logic        rx_dma_req,
   input  wire logic        rx_dma_ack,
   output var  logic [7:0]  rx_dma_data,
   input  wire logic        rx_dma_page1,
   input  wire logic        rx_dma_page2,
   output var  logic        txd,
   input  wire logic        rxd
);
   logic [3:0]  ctrl;
   logic [15:0] baud_sel;
   logic [4:0]  fmt;
   logic [5:0]  irq;
   logic [3:0]  next_ctrl;
   logic [15:0] next_baud_sel;
   logic [4:0]  next_fmt;
   logic [5:0]  next_irq;
   logic [5:0]  irq_set;
   logic [5:0]  irq_clr;
   logic [31:0] next_wb_dat_o;
   logic        next_wb_ack_o;
   logic        bus_req;
   logic        brk_evt;
   logic        ovr_evt;
   logic        tx_stopped;
   logic        rx_stopped;
   logic [15:0] bit_len;
   logic [2:0]  last_bit;

   // Both sides share one baud selection and one frame format.
   assign bit_len    = (baud_sel == 16'h0000) ? 16'h0000 : baud_sel - 16'h0001;
   assign last_bit   = fmt[spd_pkg::FMT_LEN +: 2] + spd_pkg::LEN_BASE;
   assign bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign tx_stopped = irq[spd_pkg::IRQ_TX1] | irq[spd_pkg::IRQ_TX2];
   assign rx_stopped = irq[spd_pkg::IRQ_RX1] | irq[spd_pkg::IRQ_RX2];

   logic        tx_hold_valid;
   logic [7:0]  tx_hold;
   logic        next_tx_hold_valid;
   logic [7:0]  next_tx_hold;
   logic        next_tx_dma_req;
   spd_pkg::spd_st_t tx_st;
   spd_pkg::spd_st_t next_tx_st;
   logic [15:0] tx_cnt;
   logic [15:0] next_tx_cnt;
   logic [2:0]  tx_bit;
   logic [2:0]  next_tx_bit;
   logic [7:0]  tx_sh;
   logic [7:0]  next_tx_sh;
   logic        tx_par;
   logic        next_tx_par;
   logic        next_txd;

   logic        rx_hold_valid;
   logic        next_rx_hold_valid;
   logic [7:0]  next_rx_dma_data;
   logic        next_rx_dma_req;
   spd_pkg::spd_st_t rx_st;
   spd_pkg::spd_st_t next_rx_st;
   logic [15:0] rx_cnt;
   logic [15:0] next_rx_cnt;
   logic [2:0]  rx_bit;
   logic [2:0]  next_rx_bit;
   logic [7:0]  rx_sh;
   logic [7:0]  next_rx_sh;
   logic        rx_zero;
   logic        next_rx_zero;

   // Register file and Wishbone slave.
   always_comb
   begin
      next_ctrl     = ctrl;
      next_baud_sel = baud_sel;
      next_fmt      = fmt;
      next_wb_ack_o = bus_req;
      next_wb_dat_o = 32'h00000000;
      irq_set       = 6'h00;
      irq_clr       = 6'h00;
      if (tx_dma_ack && tx_dma_req && ctrl[spd_pkg::CTRL_TXPS])
      begin
         irq_set[spd_pkg::IRQ_TX1] = tx_dma_page1 | tx_dma_page2;
         irq_set[spd_pkg::IRQ_TX2] = tx_dma_page2;
      end
      if (rx_dma_ack && rx_dma_req && ctrl[spd_pkg::CTRL_RXPS])
      begin
         irq_set[spd_pkg::IRQ_RX1] = rx_dma_page1 | rx_dma_page2;
         irq_set[spd_pkg::IRQ_RX2] = rx_dma_page2;
      end
      irq_set[spd_pkg::IRQ_BRK] = brk_evt;
      irq_set[spd_pkg::IRQ_OVR] = ovr_evt;
      if (bus_req && wb_we_i)
      begin
         // Enable writes touch only the control word; flags stay as they are.
         unique case (wb_adr_i)
            spd_pkg::OFS_CTRL:
               if (wb_sel_i[0])
                  next_ctrl = wb_dat_i[spd_pkg::CTRL_W-1:0];
            spd_pkg::OFS_BAUD:
            begin
               if (wb_sel_i[0])
                  next_baud_sel[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1])
                  next_baud_sel[15:8] = wb_dat_i[15:8];
            end
            spd_pkg::OFS_FMT:
               if (wb_sel_i[0])
                  next_fmt = wb_dat_i[spd_pkg::FMT_W-1:0];
            spd_pkg::OFS_IRQ:
               if (wb_sel_i[0])
                  irq_clr = wb_dat_i[spd_pkg::IRQ_W-1:0];
            default:
               next_ctrl = ctrl;
         endcase
      end
      if (bus_req && !wb_we_i)
      begin
         unique case (wb_adr_i)
            spd_pkg::OFS_CTRL: next_wb_dat_o[spd_pkg::CTRL_W-1:0] = ctrl;
            spd_pkg::OFS_BAUD: next_wb_dat_o[15:0] = baud_sel;
            spd_pkg::OFS_FMT:  next_wb_dat_o[spd_pkg::FMT_W-1:0] = fmt;
            spd_pkg::OFS_IRQ:  next_wb_dat_o[spd_pkg::IRQ_W-1:0] = irq;
            spd_pkg::OFS_STAT: next_wb_dat_o[3:0] = {rx_st != spd_pkg::SPD_IDLE, rx_hold_valid,
                                                     tx_st != spd_pkg::SPD_IDLE, tx_hold_valid};
            default:           next_wb_dat_o = 32'h00000000;
         endcase
      end
      // A new event in the clearing cycle keeps its flag.
      next_irq = (irq & ~irq_clr) | irq_set;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         ctrl     <= 4'h0;
         baud_sel <= spd_pkg::BAUD_RST;
         fmt      <= spd_pkg::FMT_RST;
         irq      <= 6'h00;
         wb_dat_o <= 32'h00000000;
         wb_ack_o <= 1'b0;
      end
      else if (ce)
      begin
         ctrl     <= next_ctrl;
         baud_sel <= next_baud_sel;
         fmt      <= next_fmt;
         irq      <= next_irq;
         wb_dat_o <= next_wb_dat_o;
         wb_ack_o <= next_wb_ack_o;
      end
   end

   // Transmit path: one holding word in front of the shift register.
   always_comb
   begin
      next_tx_hold_valid = tx_hold_valid;
      next_tx_hold       = tx_hold;
      next_tx_st         = tx_st;
      next_tx_cnt        = (tx_cnt == 16'h0000) ? bit_len : tx_cnt - 16'h0001;
      next_tx_bit        = tx_bit;
      next_tx_sh         = tx_sh;
      next_tx_par        = tx_par;
      next_txd           = txd;
      if (tx_dma_req && tx_dma_ack)
      begin
         next_tx_hold       = tx_dma_data;
         next_tx_hold_valid = 1'b1;
      end
      unique case (tx_st)
         spd_pkg::SPD_IDLE:
         begin
            next_txd = 1'b1;
            if (tx_hold_valid)
            begin
               // The held word leaves whether or not transmit is still enabled.
               next_tx_sh         = tx_hold;
               next_tx_hold_valid = 1'b0;
               next_tx_st         = spd_pkg::SPD_START;
               next_txd           = 1'b0;
               next_tx_cnt        = bit_len;
               next_tx_par        = fmt[spd_pkg::FMT_ODD];
            end
         end
         spd_pkg::SPD_START:
            if (tx_cnt == 16'h0000)
            begin
               next_txd    = tx_sh[0];
               next_tx_par = tx_par ^ tx_sh[0];
               next_tx_sh  = {1'b0, tx_sh[7:1]};
               next_tx_bit = 3'h0;
               next_tx_st  = spd_pkg::SPD_DATA;
            end
         spd_pkg::SPD_DATA:
            if (tx_cnt == 16'h0000)
            begin
               if (tx_bit == last_bit)
               begin
                  next_txd    = fmt[spd_pkg::FMT_PAR] ? tx_par : 1'b1;
                  next_tx_st  = fmt[spd_pkg::FMT_PAR] ? spd_pkg::SPD_PAR : spd_pkg::SPD_STOP;
                  next_tx_bit = 3'h0;
               end
               else
               begin
                  next_txd    = tx_sh[0];
                  next_tx_par = tx_par ^ tx_sh[0];
                  next_tx_sh  = {1'b0, tx_sh[7:1]};
                  next_tx_bit = tx_bit + 3'h1;
               end
            end
         spd_pkg::SPD_PAR:
            if (tx_cnt == 16'h0000)
            begin
               next_txd   = 1'b1;
               next_tx_st = spd_pkg::SPD_STOP;
            end
         spd_pkg::SPD_STOP:
            if (tx_cnt == 16'h0000)
            begin
               if (fmt[spd_pkg::FMT_STOP2] && tx_bit == 3'h0)
                  next_tx_bit = 3'h1;
               else
                  next_tx_st = spd_pkg::SPD_IDLE;
            end
         default:
            next_tx_st = spd_pkg::SPD_IDLE;
      endcase
      // An open request stays until acknowledged; a new one needs enable and no page stop.
      if (tx_dma_req)
         next_tx_dma_req = ~tx_dma_ack;
      else
         next_tx_dma_req = ctrl[spd_pkg::CTRL_TXE] & ~tx_hold_valid & ~tx_stopped;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         tx_hold_valid <= 1'b0;
         tx_hold       <= 8'h00;
         tx_dma_req    <= 1'b0;
         tx_st         <= spd_pkg::SPD_IDLE;
         tx_cnt        <= 16'h0000;
         tx_bit        <= 3'h0;
         tx_sh         <= 8'h00;
         tx_par        <= 1'b0;
         txd           <= 1'b1;
      end
      else if (ce)
      begin
         tx_hold_valid <= next_tx_hold_valid;
         tx_hold       <= next_tx_hold;
         tx_dma_req    <= next_tx_dma_req;
         tx_st         <= next_tx_st;
         tx_cnt        <= next_tx_cnt;
         tx_bit        <= next_tx_bit;
         tx_sh         <= next_tx_sh;
         tx_par        <= next_tx_par;
         txd           <= next_txd;
      end
   end

   // Receive path; reception continues through a DMA stop, so an unread word can be overwritten.
   always_comb
   begin
      next_rx_hold_valid = rx_hold_valid;
      next_rx_dma_data   = rx_dma_data;
      next_rx_st         = rx_st;
      next_rx_cnt        = (rx_cnt == 16'h0000) ? bit_len : rx_cnt - 16'h0001;
      next_rx_bit        = rx_bit;
      next_rx_sh         = rx_sh;
      next_rx_zero       = rx_zero;
      brk_evt            = 1'b0;
      ovr_evt            = 1'b0;
      if (rx_dma_req && rx_dma_ack)
         next_rx_hold_valid = 1'b0;
      unique case (rx_st)
         spd_pkg::SPD_IDLE:
            if (ctrl[spd_pkg::CTRL_RXE] && !rxd)
            begin
               next_rx_st = spd_pkg::SPD_START;
               next_rx_cnt = {1'b0, bit_len[15:1]};
            end
         spd_pkg::SPD_START:
            if (rx_cnt == 16'h0000)
            begin
               next_rx_st   = rxd ? spd_pkg::SPD_IDLE : spd_pkg::SPD_DATA;
               next_rx_bit  = 3'h0;
               next_rx_sh   = 8'h00;
               next_rx_zero = 1'b1;
            end
         spd_pkg::SPD_DATA:
            if (rx_cnt == 16'h0000)
            begin
               next_rx_sh[rx_bit] = rxd;
               next_rx_zero       = rx_zero & ~rxd;
               next_rx_bit        = rx_bit + 3'h1;
               if (rx_bit == last_bit)
                  next_rx_st = fmt[spd_pkg::FMT_PAR] ? spd_pkg::SPD_PAR : spd_pkg::SPD_STOP;
            end
         spd_pkg::SPD_PAR:
            if (rx_cnt == 16'h0000)
            begin
               next_rx_zero = rx_zero & ~rxd;
               next_rx_st   = spd_pkg::SPD_STOP;
            end
         spd_pkg::SPD_STOP:
            if (rx_cnt == 16'h0000)
            begin
               next_rx_st = spd_pkg::SPD_IDLE;
               if (!rxd)
                  brk_evt = rx_zero;
               else
               begin
                  ovr_evt            = next_rx_hold_valid;
                  next_rx_dma_data   = rx_sh;
                  next_rx_hold_valid = 1'b1;
               end
            end
         default:
            next_rx_st = spd_pkg::SPD_IDLE;
      endcase
      // Held data is offered to DMA regardless of receive enable.
      next_rx_dma_req = next_rx_hold_valid & ~rx_stopped & ~(rx_dma_req & rx_dma_ack);
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         rx_hold_valid <= 1'b0;
         rx_dma_data   <= 8'h00;
         rx_dma_req    <= 1'b0;
         rx_st         <= spd_pkg::SPD_IDLE;
         rx_cnt        <= 16'h0000;
         rx_bit        <= 3'h0;
         rx_sh         <= 8'h00;
         rx_zero       <= 1'b0;
      end
      else if (ce)
      begin
         rx_hold_valid <= next_rx_hold_valid;
         rx_dma_data   <= next_rx_dma_data;
         rx_dma_req    <= next_rx_dma_req;
         rx_st         <= next_rx_st;
         rx_cnt        <= next_rx_cnt;
         rx_bit        <= next_rx_bit;
         rx_sh         <= next_rx_sh;
         rx_zero       <= next_rx_zero;
      end
   end
endmodule
`default_nettype wire

// file: tb/spd_serial_unit_chk.sv
// Checker for the DMA serial port: register handshake and DMA request timing.
// Assumes it is bound to spd_serial_unit and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module spd_serial_unit_chk
(
   input wire logic        clock,
   input wire logic        rst,
   input wire logic        ce,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        tx_dma_req,
   input wire logic        tx_dma_ack,
   input wire logic        rx_dma_req,
   input wire logic        rx_dma_ack
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   sequence s_bus_req;  ce && wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_tx_taken; tx_dma_req && tx_dma_ack; endsequence
   sequence s_tx_open;  tx_dma_req && !tx_dma_ack; endsequence
   sequence s_rx_open;  rx_dma_req && !rx_dma_ack; endsequence
   chk_ack_latency:
   assert property (s_bus_req |=> wb_ack_o) else $error("bus ack not one cycle after request");
   chk_ack_pulse:
   assert property (wb_ack_o |=> !wb_ack_o) else $error("bus ack longer than one cycle");
   chk_ack_cause:
   assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("bus ack without request");
   chk_dat_quiet:
   assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   chk_txreq_hold:
   assert property (s_tx_open |=> tx_dma_req) else $error("open transmit request withdrawn");
   chk_txreq_gap:
   assert property (s_tx_taken |=> !tx_dma_req [*2]) else $error("transmit request too soon after ack");
   chk_rxreq_hold:
   assert property (s_rx_open |=> rx_dma_req) else $error("open receive request withdrawn");
   chk_rxreq_drop:
   assert property (rx_dma_req && rx_dma_ack |=> !rx_dma_req) else $error("receive request kept after ack");
endmodule
`default_nettype wire

// file: tb/spd_remote.sv
// Remote serial equipment: frames characters onto rxd and decodes txd.
// Assumes 8 data bits, no parity, one stop bit, BIT clocks per bit.
`timescale 1ns/1ns
`default_nettype none
module spd_remote
#(
   parameter int BIT = 4
)
(
   input  wire logic clock,
   input  wire logic txd,
   output var  logic rxd
);
   logic [7:0] got;
   int         got_n;
   initial
   begin
      rxd = 1'b1;
      got = 8'h00;
      got_n = 0;
      forever
      begin
         @(posedge clock);
         if (txd === 1'b0)
         begin
            // Mid-bit sampling keeps the decode clear of edge placement.
            repeat (BIT / 2) @(posedge clock);
            for (int i = 0; i < 8; i++)
            begin
               repeat (BIT) @(posedge clock);
               got[i] = txd;
            end
            repeat (BIT) @(posedge clock);
            got_n++;
         end
      end
   end
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clock);
         rxd <= f[i];
         repeat (BIT - 1) @(posedge clock);
      end
   endtask
endmodule
`default_nettype wire

// file: tb/serial_port_dma_page_stop_test.sv
// Testbench for the DMA serial port: register, DMA and page-stop sequences.
// Assumes the checker and remote model files are compiled first.
`timescale 1ns/1ns
`default_nettype none
module serial_port_dma_page_stop_test;
   logic        clock, rst, ce, cyc, stb, we;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [31:0] dat, wb_dat_o, q;
   logic        wb_ack_o, tx_dma_req, tx_dma_ack, tx_p1, tx_p2;
   logic        rx_dma_req, rx_dma_ack, rx_p1, rx_p2, txd, rxd;
   logic [7:0]  tx_data, rx_dma_data;
   int          error_cnt, checks, n0;
   logic [7:0]  last_tx;
   spd_serial_unit spd_serial_unit_inst (.clock(clock), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .tx_dma_req(tx_dma_req), .tx_dma_ack(tx_dma_ack), .tx_dma_data(tx_data), .tx_dma_page1(tx_p1),
      .tx_dma_page2(tx_p2), .rx_dma_req(rx_dma_req), .rx_dma_ack(rx_dma_ack), .rx_dma_data(rx_dma_data),
      .rx_dma_page1(rx_p1), .rx_dma_page2(rx_p2), .txd(txd), .rxd(rxd));
   spd_remote #(.BIT(4)) spd_remote_inst (.clock(clock), .txd(txd), .rxd(rxd));
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Codes -1 and -2 wait for a transmit or receive DMA request; others wait for a frame count.
   task automatic wait_for(input int w);
      int n;
      n = 0;
      while (!(w == -1 ? tx_dma_req === 1'b1 : w == -2 ? rx_dma_req === 1'b1 : spd_remote_inst.got_n >= w)
             && n < 3000)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 3000)
      begin
         chk(32'h0, 32'h1);
         end_sim();
      end
   endtask
   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 50);
      q = wb_dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50)
      begin
         chk(32'h0, 32'h1);
         end_sim();
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic tx_dma(input logic [7:0] d, input logic p1, input logic p2);
      wait_for(-1);
      tx_dma_ack <= 1'b1; tx_data <= d; tx_p1 <= p1; tx_p2 <= p2;
      @(posedge clock);
      tx_dma_ack <= 1'b0; tx_p1 <= 1'b0; tx_p2 <= 1'b0;
   endtask
   task automatic rx_dma(input logic p1);
      wait_for(-2);
      rx_dma_ack <= 1'b1; rx_p1 <= p1;
      @(posedge clock);
      rx_dma_ack <= 1'b0; rx_p1 <= 1'b0;
   endtask
   initial
   begin
      rst = 1'b1; ce = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 5'h00; sel = 4'h0; dat = 32'h0;
      tx_dma_ack = 1'b0; tx_data = 8'h00; tx_p1 = 1'b0; tx_p2 = 1'b0; rx_dma_ack = 1'b0; rx_p1 = 1'b0;
      rx_p2 = 1'b0; error_cnt = 0; checks = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      rd(5'h00, 32'h0); rd(5'h04, 32'h823); rd(5'h08, 32'h3); rd(5'h0C, 32'h0); rd(5'h14, 32'h0);
      wb(1'b1, 5'h04, 32'h4);
      wb(1'b1, 5'h08, 32'h3);
      // Gives the line transceiver time to settle before communication starts.
      repeat (20) @(posedge clock);
      wb(1'b1, 5'h00, 32'hF);
      rd(5'h00, 32'hF);
      // A low clock enable must freeze the open transmit request.
      ce <= 1'b0;
      repeat (5) @(posedge clock);
      chk({31'h0, tx_dma_req}, 32'h1);
      ce <= 1'b1;
      $display("test registers done");
      tx_dma(8'hA5, 1'b1, 1'b0);
      wait_for(1);
      chk({24'h0, spd_remote_inst.got}, 32'hA5);
      rd(5'h0C, 32'h1);
      chk({31'h0, tx_dma_req}, 32'h0);
      wb(1'b1, 5'h0C, 32'h1);
      tx_dma(8'h3C, 1'b0, 1'b1);
      wait_for(2);
      chk({24'h0, spd_remote_inst.got}, 32'h3C);
      rd(5'h0C, 32'h3);
      wb(1'b1, 5'h0C, 32'h3);
      $display("test transmit page stop done");
      spd_remote_inst.send(8'h3C);
      rx_dma(1'b1);
      chk({24'h0, rx_dma_data}, 32'h3C);
      rd(5'h0C, 32'h4);
      spd_remote_inst.send(8'hC3);
      repeat (4) @(posedge clock);
      chk({31'h0, rx_dma_req}, 32'h0);
      chk({24'h0, rx_dma_data}, 32'hC3);
      $display("test receive page stop done");
      n0 = spd_remote_inst.got_n;
      tx_dma(8'h96, 1'b0, 1'b0);
      last_tx = 8'h96;
      wb(1'b1, 5'h00, 32'hE);
      if (tx_dma_req === 1'b1)
      begin
         tx_dma(8'h69, 1'b0, 1'b0);
         last_tx = 8'h69;
         n0++;
      end
      wait_for(n0 + 1);
      chk({24'h0, spd_remote_inst.got}, {24'h0, last_tx});
      repeat (100) @(posedge clock);
      chk({31'h0, tx_dma_req}, 32'h0);
      chk({24'h0, 8'(spd_remote_inst.got_n - n0)}, 32'h1);
      rd(5'h0C, 32'h4);
      rd(5'h00, 32'hE);
      rd(5'h10, 32'h4);
      $display("test transmit disable done");
      wb(1'b1, 5'h0C, 32'h4);
      wait_for(-2);
      wb(1'b1, 5'h00, 32'hC);
      chk({31'h0, rx_dma_req}, 32'h1);
      rx_dma(1'b0);
      chk({24'h0, rx_dma_data}, 32'hC3);
      rd(5'h0C, 32'h0);
      rd(5'h04, 32'h4);
      $display("test receive disable done");
      wb(1'b1, 5'h00, 32'h0);
      wb(1'b1, 5'h0C, 32'h3F);
      rd(5'h0C, 32'h0);
      rd(5'h00, 32'h0);
      $display("test shutdown done");
      end_sim();
   end
endmodule
bind spd_serial_unit spd_serial_unit_chk spd_serial_unit_chk_inst (.clock(clock), .rst(rst), .ce(ce),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_dma_req(tx_dma_req),
   .tx_dma_ack(tx_dma_ack), .rx_dma_req(rx_dma_req), .rx_dma_ack(rx_dma_ack));
`default_nettype wire
